// ### core/ewc_pkg.sv
// Package for the serial EEPROM write-cycle control block.
// Assumes a 10 MHz core clock; every pin input is asynchronous to it.
package ewc_pkg;

   // Core clock period in nanoseconds
   localparam int CLK_PERIOD_NS = 100;

   // Default internal write time in nanoseconds (self-timed cycle)
   localparam int WRITE_TIME_NS = 2_000_000;

   // Device groups selectable by the variant parameter
   localparam int GROUP_MIN = 1;
   localparam int GROUP_MAX = 5;

   // Command frame layout after the start bit
   localparam int OPCODE_BITS = 2;
   localparam logic [1:0] OPC_WRITE = 2'h1;

   // Synchroniser depth for pin inputs
   localparam int SYNC_STAGES = 2;

   // Pin inputs from the host, carried together
   typedef struct packed {
      logic chipSelect;
      logic serialClk;
      logic serialDataIn;
   } ewc_pins_s;

   // Controller states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,  // Waiting for a start condition
      ST_SHIFT  = 5'h02,  // Shifting a command frame
      ST_ARMED  = 5'h04,  // Write shifted, waiting for chip-select fall
      ST_WRITE  = 5'h08,  // Internal write in progress
      ST_LOCKED = 5'h10   // Waiting for chip-select rise after write
   } ewc_state_e;

endpackage : ewc_pkg

// ### core/ewc_write_ctrl.sv
// Write-cycle start and chip-select handling of a three-wire serial EEPROM.
// Assumes chip select, serial clock and data in come straight from host pins;
// the host serial clock is slow against core_clk and is found by edge detection.
`timescale 1ns/1ps

// Contract
// R1: Groups 1,3,5 write on last data clock
// R2: Groups 2,4 write starts at CS fall
// R3: Groups 2,4 abort if input precedes CS fall
// R4: Commands ignored during internal write
// R5: Host may hold CS high after writes
// R6: Group 1 polling needs CS rise after write
// R7: Group 1 steady-high CS needs no transition
// R8: Group 1 CS change during write locks out
// R9: Host should lower CS after each write
// R10: Host should end polling by raising CS
// R11: CS high in write: busy low, then high
// R12: Groups 1-3 keep output released after write
// R13: Groups 4,5 show ready until start
// R14: Group parameter selects all variant behaviour
module ewc_write_ctrl
   import ewc_pkg::*;
#(
   parameter int GROUP         = 1,
   parameter int ADDR_BITS     = 6,
   parameter int DATA_BITS     = 16,
   parameter int WRITE_TIME_NS = ewc_pkg::WRITE_TIME_NS
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // Host pins
   input  wire ewc_pins_s  pinsIn,
   // Data out pin
   output logic            dataOut,
   output logic            dataOutEn,
   // Status
   output logic            writeBusy
);

   // Frame length and write timing
   localparam int FRAME_BITS = OPCODE_BITS + ADDR_BITS + DATA_BITS;
   localparam int CNT_W      = $clog2(FRAME_BITS + 1);
   localparam int WR_RAW     = WRITE_TIME_NS / CLK_PERIOD_NS;
   localparam int WR_CYCLES  = (WR_RAW < 1) ? 1 : WR_RAW;
   localparam int TMR_W      = $clog2(WR_CYCLES + 1);

   // Variant decode, fixed at elaboration
   localparam bit START_ON_CLK = (GROUP == 1) || (GROUP == 3) || (GROUP == 5);
   localparam bit CS_RELOCK    = (GROUP == 1);
   localparam bit READY_HOLD   = (GROUP == 4) || (GROUP == 5);

   // Refuse parameters the logic cannot serve
   if (GROUP < GROUP_MIN || GROUP > GROUP_MAX) begin : g_bad_group
      $error("GROUP must be 1 to 5");
   end
   if (ADDR_BITS < 1 || DATA_BITS < 1 || WRITE_TIME_NS < 1) begin : g_bad_size
      $error("ADDR_BITS, DATA_BITS and WRITE_TIME_NS must be positive");
   end

   // Synchroniser and edge history
   ewc_pins_s              pinsMeta_ff;
   ewc_pins_s              pinsSync_ff;
   ewc_pins_s              pinsLast_ff;
   // Control state
   ewc_state_e             state_ff;
   ewc_state_e             nxt_state;
   logic [CNT_W-1:0]       bitCnt_ff;
   logic [FRAME_BITS-1:0]  frame_ff;
   logic [TMR_W-1:0]       timer_ff;
   logic                   csMoved_ff;
   logic                   readyShow_ff;
   logic                   dataOut_ff;
   logic                   dataOutEn_ff;
   // Events
   logic                   csHigh;
   logic                   csRise;
   logic                   csFall;
   logic                   clkRise;
   logic                   startSeen;
   logic                   frameDone;
   logic                   isWrite;
   logic                   writeDone;

   // Two-flop synchroniser, then one history stage for edges
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pinsMeta_ff <= '0;
         pinsSync_ff <= '0;
         pinsLast_ff <= '0;
      end else begin
         pinsMeta_ff <= pinsIn;
         pinsSync_ff <= pinsMeta_ff;
         pinsLast_ff <= pinsSync_ff;
      end
   end

   // Edge and frame events
   assign csHigh    = pinsSync_ff.chipSelect;
   assign csRise    = csHigh && !pinsLast_ff.chipSelect;
   assign csFall    = !csHigh && pinsLast_ff.chipSelect;
   assign clkRise   = pinsSync_ff.serialClk && !pinsLast_ff.serialClk;
   assign startSeen = (state_ff == ST_IDLE) && csHigh && clkRise && pinsSync_ff.serialDataIn;
   assign frameDone = (state_ff == ST_SHIFT) && csHigh && clkRise
                      && (bitCnt_ff == CNT_W'(FRAME_BITS - 1));
   assign isWrite   = ({frame_ff[FRAME_BITS-2:0], pinsSync_ff.serialDataIn}
                       >> (FRAME_BITS - OPCODE_BITS)) == FRAME_BITS'(OPC_WRITE);
   assign writeDone = (state_ff == ST_WRITE) && (timer_ff == TMR_W'(1));

   // Next-state decode
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (startSeen) begin
               nxt_state = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (!csHigh) begin
               nxt_state = ST_IDLE;  // Frame cut short by chip select
            end else if (frameDone) begin
               if (!isWrite) begin
                  nxt_state = ST_IDLE;
               end else if (START_ON_CLK) begin
                  nxt_state = ST_WRITE;  // [R1] [R14]
               end else begin
                  nxt_state = ST_ARMED;  // [R2] [R14]
               end
            end
         end
         ST_ARMED: begin
            if (csFall) begin
               nxt_state = ST_WRITE;  // [R2]
            end else if (clkRise) begin
               nxt_state = ST_IDLE;  // Further input before the fall aborts [R3]
            end
         end
         ST_WRITE: begin
            // Serial clock and data are not decoded here [R4]
            if (writeDone) begin
               if (CS_RELOCK && (csMoved_ff || csRise)) begin
                  nxt_state = ST_LOCKED;  // [R6] [R8]
               end else begin
                  nxt_state = ST_IDLE;  // Steady high chip select goes straight on [R7]
               end
            end
         end
         ST_LOCKED: begin
            if (csRise) begin
               nxt_state = ST_IDLE;  // [R6] [R8]
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Command frame shifter
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bitCnt_ff <= '0;
         frame_ff  <= '0;
      end else if (startSeen) begin
         bitCnt_ff <= '0;
         frame_ff  <= '0;
      end else if ((state_ff == ST_SHIFT) && csHigh && clkRise) begin
         bitCnt_ff <= bitCnt_ff + CNT_W'(1);
         frame_ff  <= {frame_ff[FRAME_BITS-2:0], pinsSync_ff.serialDataIn};
      end
   end

   // Self-timed write counter
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         timer_ff <= '0;
      end else if ((state_ff != ST_WRITE) && (nxt_state == ST_WRITE)) begin
         timer_ff <= TMR_W'(WR_CYCLES);
      end else if (state_ff == ST_WRITE) begin
         timer_ff <= timer_ff - TMR_W'(1);
      end
   end

   // Chip-select rise seen during the write, for the relock decision
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         csMoved_ff <= 1'b0;
      end else if ((state_ff != ST_WRITE) && (nxt_state == ST_WRITE)) begin
         csMoved_ff <= 1'b0;
      end else if ((state_ff == ST_WRITE) && csRise) begin
         csMoved_ff <= 1'b1;  // Polling or toggling during write [R6] [R8]
      end
   end

   // Ready indication held after write end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         readyShow_ff <= 1'b0;
      end else if (writeDone && csHigh) begin
         readyShow_ff <= 1'b1;  // Busy turns to ready with chip select high [R11]
      end else if (startSeen || !csHigh) begin
         readyShow_ff <= 1'b0;  // [R13]
      end else if (csRise && READY_HOLD && (state_ff != ST_WRITE)) begin
         readyShow_ff <= 1'b1;  // Ready driven on late rise [R13] [R14]
      end
      // Groups 1-3 leave the pin released on a late rise [R12]
   end

   // Data-out pin registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dataOut_ff   <= 1'b0;
         dataOutEn_ff <= 1'b0;
      end else begin
         dataOutEn_ff <= csHigh && ((nxt_state == ST_WRITE) || (readyShow_ff && !startSeen)
                         || (writeDone && csHigh));
         dataOut_ff   <= (nxt_state != ST_WRITE);  // Low while busy [R11]
      end
   end

   // Outputs
   assign dataOut   = dataOut_ff;
   assign dataOutEn = dataOutEn_ff;
   assign writeBusy = (state_ff == ST_WRITE);

endmodule : ewc_write_ctrl

// ### tb/ewc_write_ctrl_monitor.sv
// Checker for the write-cycle controller, bound to every instance.
// Assumes pin inputs change away from the rising core_clk edge.
`timescale 1ns/1ps
module ewc_write_ctrl_monitor
   import ewc_pkg::*;
#(
   parameter int GROUP         = 1,
   parameter int WRITE_TIME_NS = 500
) (
   // Clock and reset
   input wire logic      core_clk,
   input wire logic      resetn,
   // Pins and status
   input wire ewc_pins_s pinsIn,
   input wire logic      dataOut,
   input wire logic      dataOutEn,
   input wire logic      writeBusy
);
   localparam int WR = WRITE_TIME_NS / CLK_PERIOD_NS;
   logic [31:0] busyCnt_ff;
   wire         cs   = pinsIn.chipSelect;
   wire         sclk = pinsIn.serialClk;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // Counts busy cycles of the running write
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         busyCnt_ff <= '0;
      else
         busyCnt_ff <= writeBusy ? busyCnt_ff + 32'h1 : '0;
   end
   sequence s_idleRise;
      (!writeBusy)[*8] ##0 $rose(cs);
   endsequence
   property p_busyLen;
      $fell(writeBusy) |-> busyCnt_ff == WR;
   endproperty
   property p_clkStart;
      $rose(writeBusy) |-> GROUP % 2 == 0 || $past(sclk, 3) && !$past(sclk, 5);
   endproperty
   property p_csStart;
      $rose(writeBusy) |-> GROUP % 2 == 1 || !$past(cs, 2) && $past(cs, 6);
   endproperty
   property p_pollLow;
      $past(writeBusy) && writeBusy && dataOutEn |-> !dataOut;
   endproperty
   property p_doneHigh;
      $fell(writeBusy) && cs && $past(cs, 8) |-> dataOut && dataOutEn;
   endproperty
   property p_riseHiZ;
      s_idleRise |=> (GROUP > 3 || !dataOutEn)[*8];
   endproperty
   property p_riseReady;
      s_idleRise |-> ##[1:8] (GROUP < 4 || dataOut && dataOutEn);
   endproperty
   property p_startRel;
      GROUP > 1 && !writeBusy && dataOutEn && cs && pinsIn.serialDataIn && $rose(sclk) |-> ##[1:8] !dataOutEn;
   endproperty
   a_busyLen: assert property (p_busyLen) else $error("write length wrong");
   a_clkStart: assert property (p_clkStart) else $error("write not at last clock");
   a_csStart: assert property (p_csStart) else $error("write not at select fall");
   a_pollLow: assert property (p_pollLow) else $error("busy not low");
   a_doneHigh: assert property (p_doneHigh) else $error("ready not high");
   a_riseHiZ: assert property (p_riseHiZ) else $error("output not released");
   a_riseReady: assert property (p_riseReady) else $error("no ready drive");
   a_startRel: assert property (p_startRel) else $error("ready kept after start");
endmodule : ewc_write_ctrl_monitor

bind ewc_write_ctrl ewc_write_ctrl_monitor #(
   .GROUP        (GROUP),
   .WRITE_TIME_NS(WRITE_TIME_NS)
) u_mon (
   .core_clk (core_clk),
   .resetn   (resetn),
   .pinsIn   (pinsIn),
   .dataOut  (dataOut),
   .dataOutEn(dataOutEn),
   .writeBusy(writeBusy)
);

// ### tb/ewc_host_model.sv
// Host model driving select, serial clock and data in.
// Assumes tasks are entered just after a falling core_clk edge.
`timescale 1ns/1ps
module ewc_host_model
   import ewc_pkg::*;
(
   // Pacing clock
   input wire logic core_clk,
   // Pins toward the device
   output ewc_pins_s pins
);
   localparam int HALF = 4;
   // Serial clock rests low outside frames
   initial pins = '0;
   // Hold all pins for n clocks
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask : idle
   // Select raise, free in time for the host; also ends a polling spell
   task automatic raiseCs();
      @(negedge core_clk);
      pins.chipSelect = 1'h1;
   endtask : raiseCs
   // Select drop, as a portable host does after every write
   task automatic lowerCs();
      @(negedge core_clk);
      pins.chipSelect = 1'h0;
   endtask : lowerCs
   // Shift n bits MSB first, 800 ns per bit, select left as it is
   task automatic shift(input logic [24:0] bits, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         pins.serialDataIn = bits[i];
         idle(HALF);
         pins.serialClk = 1'h1;
         idle(HALF);
         pins.serialClk = 1'h0;
      end
   endtask : shift
endmodule : ewc_host_model

// ### tb/tb_ewc_write_ctrl.sv
// Testbench: a group 1 and a group 4 controller share one host.
// Assumes a shortened write time of 3000 core clocks.
`timescale 1ns/1ps
module tb_ewc_write_ctrl
   import ewc_pkg::*;
;
   localparam int WRT = 300_000;
   localparam int WR  = WRT / CLK_PERIOD_NS;
   logic      core_clk;
   logic      resetn;
   ewc_pins_s pins;
   logic      busy1, out1, en1, busy4, out4, en4;
   int        fails;
   int        checks;
   int        exp[$];
   time       t0;
   ewc_write_ctrl #(.GROUP(1), .WRITE_TIME_NS(WRT)) dut (.core_clk(core_clk), .resetn(resetn),
      .pinsIn(pins), .dataOut(out1), .dataOutEn(en1), .writeBusy(busy1));
   ewc_write_ctrl #(.GROUP(4), .WRITE_TIME_NS(WRT)) dut4 (.core_clk(core_clk), .resetn(resetn),
      .pinsIn(pins), .dataOut(out4), .dataOutEn(en4), .writeBusy(busy4));
   ewc_host_model host (.core_clk(core_clk), .pins(pins));
   // 10 MHz clock
   initial begin
      core_clk = 1'h0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         fails++;
         $display("[FAIL] %0t seen %0h want %0h", $time, seen, want);
      end
   endtask : check
   task automatic conclude();
      check(exp.size(), 0);
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   // Random write frame; note a group 1 write when one is due
   task automatic wr(input logic note);
      host.shift({1'h1, OPC_WRITE, 22'($urandom)}, 25);
      if (note)
         exp.push_back(WR);
   endtask : wr
   // Each group 1 write is timed against the oldest note
   always @(posedge busy1)
      t0 = $time;
   always @(negedge busy1) begin
      if (resetn)
         check(32'(($time - t0) / CLK_PERIOD_NS), exp.size() ? exp.pop_front() : 0);
   end
   // Watchdog
   initial begin
      #4_000_000;
      fails++;
      conclude();
   end
   // Scenarios
   initial begin
      resetn = 1'h0;
      void'($urandom(32'he294_b4b8));
      host.idle(16);
      resetn = 1'h1;
      host.idle(4);
      host.raiseCs();
      wr(1'h1);
      host.idle(WR + 50 + $urandom_range(100));
      check(busy4, 0);
      check(out1, 1);
      wr(1'h1);
      host.lowerCs();
      host.idle(WR + 50 + $urandom_range(100));
      $display("test hold-high done");
      host.raiseCs();
      wr(1'h1);
      host.lowerCs();
      host.idle(4 + $urandom_range(8));
      check(busy4, 1);
      host.raiseCs();
      wr(1'h0);
      host.idle(WR + $urandom_range(100));
      check(out1, 1);
      wr(1'h0);
      host.lowerCs();
      host.idle(WR + 50 + $urandom_range(100));
      host.raiseCs();
      host.idle(4 + $urandom_range(8));
      check(en1, 0);
      check({en4, out4}, 2'h3);
      $display("test polling done");
      wr(1'h1);
      check(en4, 0);
      host.shift(25'($urandom), 1);
      host.lowerCs();
      host.idle(4 + $urandom_range(8));
      check(busy4, 0);
      host.idle(WR + 50 + $urandom_range(100));
      $display("test recovery done");
      conclude();
   end
endmodule : tb_ewc_write_ctrl
